// ===== csdr_consts.vh
// Constants for the clock, SYSREF and delay-line configuration register slice
`ifndef CSDR_CONSTS_VH
`define CSDR_CONSTS_VH

// ==========================================================================
// Serial port framing
`define CSDR_ADDR_W 15
`define CSDR_CMD_LAST 4'hf
`define CSDR_DATA_LAST 4'h7
`define CSDR_BIT_ZERO 4'h0
`define CSDR_BIT_STEP 4'h1
`define CSDR_ADDR_STEP 15'h0001

// ==========================================================================
// Register offsets
`define CSDR_OFS_REF_CTRL 15'h0084
`define CSDR_OFS_SYSREF_HI 15'h0088
`define CSDR_OFS_SYSREF_LO 15'h0089
`define CSDR_OFS_DLL 15'h0090

// ==========================================================================
// Register indices
`define CSDR_NUM_REGS 4
`define CSDR_IDX_REF_CTRL 0
`define CSDR_IDX_SYSREF_HI 1
`define CSDR_IDX_SYSREF_LO 2
`define CSDR_IDX_DLL 3

// ==========================================================================
// Writable bits and reset values
`define CSDR_MASK_REF_CTRL 8'h31
`define CSDR_MASK_SYSREF_HI 8'h0f
`define CSDR_MASK_SYSREF_LO 8'hff
`define CSDR_MASK_DLL 8'h1f
`define CSDR_RST_REF_CTRL 8'h00
`define CSDR_RST_SYSREF_HI 8'h00
`define CSDR_RST_SYSREF_LO 8'h00
`define CSDR_RST_DLL 8'h1f

// ==========================================================================
// Field positions
`define CSDR_REF_RATE_MSB 5
`define CSDR_REF_RATE_LSB 4
`define CSDR_REF_PD_BIT 0
`define CSDR_HYST_EN_BIT 3
`define CSDR_RISE_BIT 2
`define CSDR_HYS_HI_MSB 1
`define CSDR_HYS_HI_LSB 0
`define CSDR_FINE_DC_BIT 4
`define CSDR_FINE_XC_BIT 3
`define CSDR_COARSE_DC_BIT 2
`define CSDR_COARSE_XC_BIT 1
`define CSDR_CLKGEN_PD_BIT 0
`define CSDR_HYS_W 10

// ==========================================================================
// Reference clock rate codes
`define CSDR_RATE_1X 2'h0
`define CSDR_RATE_2X 2'h1
`define CSDR_RATE_4X 2'h2
`define CSDR_RATE_OFF 2'h3

`endif

// ===== csdr_field_reg.v
// One 8-bit configuration register with reset value and writable-bit mask
`timescale 1ns/100ps

module csdr_field_reg
#(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] value
);

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      value <= RESET_VAL;
    end
    else if (wr_en)
    begin
      value <= wr_data & WR_MASK; // RULE10
    end
  end

endmodule

// ===== csdr_config_regs.v
// Clock, SYSREF and delay-line configuration registers behind the serial port
//
// Notes on behaviour
// RULE1: Rate field selects 1x, 2x, 4x reference.
// RULE2: Rate code 11 disables loop reference clock.
// RULE3: Bit 0 set powers reference clock down.
// RULE4: Bit 3 enables programmable SYSREF hysteresis.
// RULE5: Bit 2 selects SYSREF rising edge.
// RULE6: Ten-bit hysteresis amount split over two registers.
// RULE7: Fine line correction enables, reset one.
// RULE8: Coarse line correction enables, reset one.
// RULE9: Bit 0 powers down loop and clockgen.
// RULE10: Reserved bits read zero, ignore writes.
// RULE11: Fields written over serial port, then applied.
`timescale 1ns/100ps
`include "csdr_consts.vh"

module csdr_config_regs
(
  input wire ref_clk,
  input wire rst_b,
  input wire spi_cs_b,
  input wire spi_sclk,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  output reg loop_ref_clock_powerdown,
  output reg loop_ref_clock_disable,
  output reg [1:0] ref_clock_rate_mult,
  output reg ref_clock_mult_2x,
  output reg ref_clock_mult_4x,
  output reg sysref_hysteresis_enable,
  output reg sysref_rising_edge_select,
  output reg [9:0] sysref_hysteresis_amount,
  output reg [9:0] sysref_hysteresis_applied,
  output reg fine_line_duty_correct_en,
  output reg fine_line_cross_control_en,
  output reg coarse_line_duty_correct_en,
  output reg coarse_line_cross_control_en,
  output reg lock_loop_clockgen_powerdown
);

  // ==========================================================================
  // Register table
  localparam NREG = `CSDR_NUM_REGS;
  localparam AW = `CSDR_ADDR_W;
  localparam [4*AW-1:0] REG_OFS =
    {`CSDR_OFS_DLL, `CSDR_OFS_SYSREF_LO, `CSDR_OFS_SYSREF_HI, `CSDR_OFS_REF_CTRL};
  localparam [31:0] REG_RST =
    {`CSDR_RST_DLL, `CSDR_RST_SYSREF_LO, `CSDR_RST_SYSREF_HI, `CSDR_RST_REF_CTRL};
  localparam [31:0] REG_MASK =
    {`CSDR_MASK_DLL, `CSDR_MASK_SYSREF_LO, `CSDR_MASK_SYSREF_HI, `CSDR_MASK_REF_CTRL};
  localparam [7:0] RST_REF = `CSDR_RST_REF_CTRL;
  localparam [7:0] RST_SYS_HI = `CSDR_RST_SYSREF_HI;
  localparam [7:0] RST_SYS_LO = `CSDR_RST_SYSREF_LO;
  localparam [7:0] RST_DLL = `CSDR_RST_DLL;

  // ==========================================================================
  // Frame states
  localparam ST_CMD = 1'b0;
  localparam ST_DATA = 1'b1;

  // ==========================================================================
  // Address decode, one-hot over the register table
  function [NREG-1:0] csdr_reg_sel;
    input [AW-1:0] addr;
    integer k;
    begin
      csdr_reg_sel = {NREG{1'b0}};
      for (k = 0; k < NREG; k = k + 1)
      begin
        if (addr == REG_OFS[k*AW +: AW])
        begin
          csdr_reg_sel[k] = 1'b1;
        end
      end
    end
  endfunction

  // ==========================================================================
  // Serial frame engine
  reg sclk_d;
  reg state;
  reg [3:0] bit_cnt;
  reg [14:0] cmd_shift;
  reg rd_mode;
  reg [AW-1:0] cur_addr;
  reg [6:0] data_shift;
  reg wr_pulse;
  reg [AW-1:0] wr_addr;
  reg [7:0] wr_byte;
  reg load_pending;
  reg [7:0] sdo_shift;
  wire sclk_rise;
  wire sclk_fall;
  wire [7:0] rd_value;

  assign sclk_rise = ~spi_cs_b & spi_sclk & ~sclk_d;
  assign sclk_fall = ~spi_cs_b & ~spi_sclk & sclk_d;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= spi_sclk;
    end
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_CMD;
      bit_cnt <= `CSDR_BIT_ZERO;
      cmd_shift <= 15'h0000;
      rd_mode <= 1'b0;
      cur_addr <= {AW{1'b0}};
      data_shift <= 7'h00;
      wr_pulse <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_byte <= 8'h00;
      load_pending <= 1'b0;
    end
    else if (spi_cs_b)
    begin
      state <= ST_CMD;
      bit_cnt <= `CSDR_BIT_ZERO;
      rd_mode <= 1'b0;
      wr_pulse <= 1'b0;
      load_pending <= 1'b0;
    end
    else
    begin
      wr_pulse <= 1'b0;
      load_pending <= 1'b0;
      if (sclk_rise)
      begin
        case (state)
          ST_CMD:
          begin
            cmd_shift <= {cmd_shift[13:0], spi_sdi};
            if (bit_cnt == `CSDR_CMD_LAST)
            begin
              state <= ST_DATA;
              bit_cnt <= `CSDR_BIT_ZERO;
              rd_mode <= cmd_shift[14];
              cur_addr <= {cmd_shift[13:0], spi_sdi};
              load_pending <= cmd_shift[14];
            end
            else
            begin
              bit_cnt <= bit_cnt + `CSDR_BIT_STEP;
            end
          end
          ST_DATA:
          begin
            data_shift <= {data_shift[5:0], spi_sdi};
            if (bit_cnt == `CSDR_DATA_LAST)
            begin
              bit_cnt <= `CSDR_BIT_ZERO;
              wr_pulse <= ~rd_mode; // RULE11
              wr_addr <= cur_addr;
              wr_byte <= {data_shift, spi_sdi};
              cur_addr <= cur_addr + `CSDR_ADDR_STEP;
              load_pending <= rd_mode;
            end
            else
            begin
              bit_cnt <= bit_cnt + `CSDR_BIT_STEP;
            end
          end
          default:
          begin
            state <= ST_CMD;
            bit_cnt <= `CSDR_BIT_ZERO;
          end
        endcase
      end
    end
  end

  // Read data: loaded after the address or a finished byte, shifted on falls
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdo_shift <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      if (load_pending)
      begin
        sdo_shift <= {rd_value[6:0], 1'b0};
        spi_sdo <= rd_value[7]; // RULE11
      end
      else if (sclk_fall && (state == ST_DATA) && (bit_cnt != `CSDR_BIT_ZERO))
      begin
        sdo_shift <= {sdo_shift[6:0], 1'b0};
        spi_sdo <= sdo_shift[7];
      end
      spi_sdo_oe <= ~spi_cs_b & (state == ST_DATA) & rd_mode;
    end
  end

  // ==========================================================================
  // Register storage and read-back
  wire [NREG-1:0] wr_sel;
  wire [NREG-1:0] rd_sel;
  wire [8*NREG-1:0] reg_value;
  wire [8*NREG-1:0] rd_terms;
  reg [7:0] rd_or;
  integer j;

  assign wr_sel = csdr_reg_sel(wr_addr);
  assign rd_sel = csdr_reg_sel(cur_addr);

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1)
    begin : g_reg
      csdr_field_reg
      #(
        .RESET_VAL(REG_RST[8*g +: 8]),
        .WR_MASK(REG_MASK[8*g +: 8])
      )
      u_reg
      (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(wr_pulse & wr_sel[g]), // RULE11
        .wr_data(wr_byte),
        .value(reg_value[8*g +: 8])
      );
      assign rd_terms[8*g +: 8] = rd_sel[g] ? reg_value[8*g +: 8] : 8'h00;
    end
  endgenerate

  // Unmapped addresses read zero
  always @*
  begin
    rd_or = 8'h00;
    for (j = 0; j < NREG; j = j + 1)
    begin
      rd_or = rd_or | rd_terms[8*j +: 8];
    end
  end

  assign rd_value = rd_or; // RULE10

  // ==========================================================================
  // Clock circuitry outputs
  wire [7:0] ref_ctrl;
  wire [7:0] sys_hi;
  wire [7:0] sys_lo;
  wire [7:0] dll_ctrl;
  wire [1:0] rate_code;
  wire [9:0] hys_amount;

  assign ref_ctrl = reg_value[8*`CSDR_IDX_REF_CTRL +: 8];
  assign sys_hi = reg_value[8*`CSDR_IDX_SYSREF_HI +: 8];
  assign sys_lo = reg_value[8*`CSDR_IDX_SYSREF_LO +: 8];
  assign dll_ctrl = reg_value[8*`CSDR_IDX_DLL +: 8];
  assign rate_code = ref_ctrl[`CSDR_REF_RATE_MSB:`CSDR_REF_RATE_LSB];
  assign hys_amount = {sys_hi[`CSDR_HYS_HI_MSB:`CSDR_HYS_HI_LSB], sys_lo}; // RULE6

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_ref_clock_powerdown <= RST_REF[`CSDR_REF_PD_BIT];
      ref_clock_rate_mult <= RST_REF[`CSDR_REF_RATE_MSB:`CSDR_REF_RATE_LSB];
      loop_ref_clock_disable <= 1'b0;
      ref_clock_mult_2x <= 1'b0;
      ref_clock_mult_4x <= 1'b0;
      sysref_hysteresis_enable <= RST_SYS_HI[`CSDR_HYST_EN_BIT];
      sysref_rising_edge_select <= RST_SYS_HI[`CSDR_RISE_BIT];
      sysref_hysteresis_amount <= {RST_SYS_HI[`CSDR_HYS_HI_MSB:`CSDR_HYS_HI_LSB], RST_SYS_LO};
      sysref_hysteresis_applied <= {`CSDR_HYS_W{1'b0}};
      fine_line_duty_correct_en <= RST_DLL[`CSDR_FINE_DC_BIT];
      fine_line_cross_control_en <= RST_DLL[`CSDR_FINE_XC_BIT];
      coarse_line_duty_correct_en <= RST_DLL[`CSDR_COARSE_DC_BIT];
      coarse_line_cross_control_en <= RST_DLL[`CSDR_COARSE_XC_BIT];
      lock_loop_clockgen_powerdown <= RST_DLL[`CSDR_CLKGEN_PD_BIT];
    end
    else
    begin
      loop_ref_clock_powerdown <= ref_ctrl[`CSDR_REF_PD_BIT]; // RULE3
      ref_clock_rate_mult <= rate_code; // RULE1
      loop_ref_clock_disable <= (rate_code == `CSDR_RATE_OFF); // RULE2
      ref_clock_mult_2x <= (rate_code == `CSDR_RATE_2X); // RULE1
      ref_clock_mult_4x <= (rate_code == `CSDR_RATE_4X); // RULE1
      sysref_hysteresis_enable <= sys_hi[`CSDR_HYST_EN_BIT]; // RULE4
      sysref_rising_edge_select <= sys_hi[`CSDR_RISE_BIT]; // RULE5
      sysref_hysteresis_amount <= hys_amount; // RULE6
      sysref_hysteresis_applied <= sys_hi[`CSDR_HYST_EN_BIT] ? hys_amount
                                                             : {`CSDR_HYS_W{1'b0}}; // RULE4
      fine_line_duty_correct_en <= dll_ctrl[`CSDR_FINE_DC_BIT]; // RULE7
      fine_line_cross_control_en <= dll_ctrl[`CSDR_FINE_XC_BIT]; // RULE7
      coarse_line_duty_correct_en <= dll_ctrl[`CSDR_COARSE_DC_BIT]; // RULE8
      coarse_line_cross_control_en <= dll_ctrl[`CSDR_COARSE_XC_BIT]; // RULE8
      lock_loop_clockgen_powerdown <= dll_ctrl[`CSDR_CLKGEN_PD_BIT]; // RULE9
    end
  end

endmodule

// ===== csdr_config_regs_sva.sv
// Checker for the clock, SYSREF and delay-line configuration register slice
`timescale 1ns/100ps

module csdr_chk
(
  input logic ref_clk,
  input logic rst_b,
  input logic spi_cs_b,
  input logic spi_sclk,
  input logic spi_sdi,
  input logic spi_sdo,
  input logic spi_sdo_oe,
  input logic loop_ref_clock_powerdown,
  input logic loop_ref_clock_disable,
  input logic [1:0] ref_clock_rate_mult,
  input logic ref_clock_mult_2x,
  input logic ref_clock_mult_4x,
  input logic sysref_hysteresis_enable,
  input logic sysref_rising_edge_select,
  input logic [9:0] sysref_hysteresis_amount,
  input logic [9:0] sysref_hysteresis_applied,
  input logic fine_line_duty_correct_en,
  input logic fine_line_cross_control_en,
  input logic coarse_line_duty_correct_en,
  input logic coarse_line_cross_control_en,
  input logic lock_loop_clockgen_powerdown
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Rate decode
  property p_rate_off;
    loop_ref_clock_disable == (ref_clock_rate_mult == 2'h3);
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("rate off decode wrong");
  property p_rate_2x;
    ref_clock_mult_2x == (ref_clock_rate_mult == 2'h1);
  endproperty
  a_rate_2x: assert property (p_rate_2x) else $error("double rate decode wrong");
  property p_rate_4x;
    ref_clock_mult_4x == (ref_clock_rate_mult == 2'h2);
  endproperty
  a_rate_4x: assert property (p_rate_4x) else $error("quad rate decode wrong");

  // ==========================================================================
  // Hysteresis gating and reset state
  property p_hys_gate;
    sysref_hysteresis_applied == (sysref_hysteresis_enable ? sysref_hysteresis_amount : 10'h000);
  endproperty
  a_hys_gate: assert property (p_hys_gate) else $error("hysteresis gating wrong");
  property p_reset_vals;
    $rose(rst_b) |-> fine_line_duty_correct_en && fine_line_cross_control_en
      && coarse_line_duty_correct_en && coarse_line_cross_control_en
      && lock_loop_clockgen_powerdown && !loop_ref_clock_powerdown;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // ==========================================================================
  // Nothing changes outside a frame
  property p_quiet_dll;
    spi_cs_b [*3] |=> $stable({fine_line_duty_correct_en, fine_line_cross_control_en,
      coarse_line_duty_correct_en, coarse_line_cross_control_en, lock_loop_clockgen_powerdown});
  endproperty
  a_quiet_dll: assert property (p_quiet_dll) else $error("delay line field moved idle");
  property p_quiet_sys;
    spi_cs_b [*3] |=> $stable({sysref_hysteresis_amount, ref_clock_rate_mult,
      loop_ref_clock_powerdown});
  endproperty
  a_quiet_sys: assert property (p_quiet_sys) else $error("sysref field moved idle");
  property p_oe_idle;
    spi_cs_b |=> !spi_sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
endmodule

// ===== csdr_config_regs_bench.sv
// Self-checking bench for the configuration register slice
`timescale 1ns/100ps
`include "csdr_consts.vh"

module csdr_config_regs_bench;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg spi_cs_b = 1'b1;
  reg spi_sclk = 1'b0;
  reg spi_sdi = 1'b0;
  wire sdo, oe, rpd, rdis, m2, m4, hen, rise, fdc, fxc, cdc, cxc, cpd;
  wire [1:0] rate;
  wire [9:0] amt, app;
  integer fails = 0;
  integer compares = 0;
  integer k, j;
  reg [7:0] model [0:3];
  reg [7:0] msk [0:3];
  reg [14:0] adr [0:5];
  reg [7:0] q, d;

  always #2 ref_clk = ~ref_clk;

  csdr_config_regs csdr_config_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(sdo),
    .spi_sdo_oe(oe), .loop_ref_clock_powerdown(rpd), .loop_ref_clock_disable(rdis),
    .ref_clock_rate_mult(rate), .ref_clock_mult_2x(m2), .ref_clock_mult_4x(m4),
    .sysref_hysteresis_enable(hen), .sysref_rising_edge_select(rise),
    .sysref_hysteresis_amount(amt), .sysref_hysteresis_applied(app),
    .fine_line_duty_correct_en(fdc), .fine_line_cross_control_en(fxc),
    .coarse_line_duty_correct_en(cdc), .coarse_line_cross_control_en(cxc),
    .lock_loop_clockgen_powerdown(cpd));

  task test_done;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [8*8:1] nm, input [9:0] seen, input [9:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task check_pins;
    begin
      chk("rate", {8'h00, rate}, {8'h00, model[0][5:4]});
      chk("mult", {8'h00, m2, m4}, {8'h00, model[0][5:4] == 2'h1, model[0][5:4] == 2'h2});
      chk("disable", {9'h000, rdis}, {9'h000, model[0][5:4] == 2'h3});
      chk("refpd", {9'h000, rpd}, {9'h000, model[0][0]});
      chk("hyson", {9'h000, hen}, {9'h000, model[1][3]});
      chk("applied", app, model[1][3] ? {model[1][1:0], model[2]} : 10'h000);
      chk("rise", {9'h000, rise}, {9'h000, model[1][2]});
      chk("amount", amt, {model[1][1:0], model[2]});
      chk("fine", {8'h00, fdc, fxc}, {8'h00, model[3][4:3]});
      chk("coarse", {8'h00, cdc, cxc}, {8'h00, model[3][2:1]});
      chk("dllpd", {9'h000, cpd}, {9'h000, model[3][0]});
    end
  endtask

  // Mode 0 frame, n bits sent, sclk phases of four cycles
  task frame(input rw, input [14:0] a, input [7:0] dv, input integer n);
    reg [31:0] w;
    integer i;
    begin
      w = {rw, a, dv, dv};
      q = 8'h00;
      @(negedge ref_clk) spi_cs_b = 1'b0;
      for (i = 0; i < n; i = i + 1)
      begin
        spi_sdi = w[31 - i];
        repeat (4) @(negedge ref_clk);
        // Master samples as it raises sclk
        if (i > 15)
          q = {q[6:0], sdo};
        spi_sclk = 1'b1;
        repeat (2) @(negedge ref_clk);
        if (i > 15 && rw)
          chk("sdo_oe", {9'h000, oe}, 10'h001);
        repeat (2) @(negedge ref_clk);
        spi_sclk = 1'b0;
      end
      spi_sdi = ~spi_sdi;
      repeat (4) @(negedge ref_clk);
      spi_cs_b = 1'b1;
      repeat (4) @(negedge ref_clk);
    end
  endtask

  task wr(input integer r, input [7:0] dv);
    begin
      frame(1'b0, adr[r], dv, 24);
      if (r < 4)
        model[r] = dv & msk[r];
      check_pins;
    end
  endtask

  task rd(input integer r);
    begin
      frame(1'b1, adr[r], 8'h00, 24);
      chk("readback", {2'h0, q}, {2'h0, r < 4 ? model[r] : 8'h00});
    end
  endtask

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    fails = fails + 1;
    test_done;
  end

  initial
  begin
    k = $urandom(93);
    adr[0] = `CSDR_OFS_REF_CTRL;
    adr[1] = `CSDR_OFS_SYSREF_HI;
    adr[2] = `CSDR_OFS_SYSREF_LO;
    adr[3] = `CSDR_OFS_DLL;
    adr[4] = 15'h0085;
    adr[5] = 15'h0091;
    msk[0] = 8'h31;
    msk[1] = 8'h0f;
    msk[2] = 8'hff;
    msk[3] = 8'h1f;
    model[0] = 8'h00;
    model[1] = 8'h00;
    model[2] = 8'h00;
    model[3] = 8'h1f;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    check_pins;
    for (k = 0; k < 6; k = k + 1)
      rd(k);
    for (j = 0; j < 4; j = j + 1)
    begin
      d = $urandom;
      wr(0, {d[7:6], j[1:0], d[3:0]});
    end
    wr(1, 8'hff);
    wr(2, 8'h00);
    wr(2, 8'hff);
    wr(3, 8'h00);
    wr(4, 8'hff);
    for (j = 0; j < 40; j = j + 1)
    begin
      k = $urandom % 6;
      d = $urandom;
      wr(k, d);
      rd(k);
    end
    // Two-byte frames stream to the next address
    d = $urandom;
    frame(1'b0, adr[1], d, 32);
    model[1] = d & msk[1];
    model[2] = d;
    check_pins;
    frame(1'b1, adr[1], 8'h00, 32);
    chk("stream", {2'h0, q}, {2'h0, model[2]});
    // Aborted byte must leave the register alone
    frame(1'b0, adr[3], ~model[3], 20);
    check_pins;
    rd(3);
    test_done;
  end
endmodule

bind csdr_config_regs csdr_chk csdr_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b),
  .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
  .spi_sdo_oe(spi_sdo_oe), .loop_ref_clock_powerdown(loop_ref_clock_powerdown),
  .loop_ref_clock_disable(loop_ref_clock_disable), .ref_clock_rate_mult(ref_clock_rate_mult),
  .ref_clock_mult_2x(ref_clock_mult_2x), .ref_clock_mult_4x(ref_clock_mult_4x),
  .sysref_hysteresis_enable(sysref_hysteresis_enable),
  .sysref_rising_edge_select(sysref_rising_edge_select),
  .sysref_hysteresis_amount(sysref_hysteresis_amount),
  .sysref_hysteresis_applied(sysref_hysteresis_applied),
  .fine_line_duty_correct_en(fine_line_duty_correct_en),
  .fine_line_cross_control_en(fine_line_cross_control_en),
  .coarse_line_duty_correct_en(coarse_line_duty_correct_en),
  .coarse_line_cross_control_en(coarse_line_cross_control_en),
  .lock_loop_clockgen_powerdown(lock_loop_clockgen_powerdown));
